// >>> design/zaal_annunciator.sv
// eight-zone alarm annunciator logic with an AXI4-Lite register slave
`timescale 1ns/1ps

module zaal_annunciator
	import zaal_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = ZAAL_DEBOUNCE_CYCLES,
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ZAAL_ZONES-1:0] zone_alarm,
	input wire logic [ZAAL_ZONES-1:0] zone_trouble,
	input wire logic [ZAAL_ZONES-1:0] zone_button_n,
	input wire logic [ZAAL_CTLS-1:0] ctl_n,
	output logic [ZAAL_ZONES-1:0] zone_sink,
	output logic [ZAAL_COMMONS-1:0] common_sink,
	output logic sounder,
	output logic [ZAAL_ZONES-1:0] shunt_ind
);

	localparam int NIN = 3 * ZAAL_ZONES + ZAAL_CTLS;
	localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [CW-1:0] DB_LAST = CW'(DEBOUNCE_CYCLES - 1);

	// ----------------------------------------------------------------
	// input synchroniser and debounce
	// ----------------------------------------------------------------
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] sync1;
	logic [NIN-1:0] sync2;
	logic [NIN-1:0] clean;

	// controls and buttons are active low at the pins
	assign raw_in = {~ctl_n, ~zone_button_n, zone_trouble, zone_alarm};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	generate
		for (genvar g = 0; g < NIN; g++)
		begin : g_db
			logic [CW-1:0] cnt;
			// a level must hold for the whole window before it is believed
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					cnt <= '0;
					clean[g] <= 1'b0;
				end
				else if (sync2[g] == clean[g])
					cnt <= '0;
				else if (cnt == DB_LAST)
				begin
					cnt <= '0;
					clean[g] <= sync2[g];
				end
				else
					cnt <= cnt + 1'b1;
			end
		end
	endgenerate

	logic [ZAAL_ZONES-1:0] alarm_in;
	logic [ZAAL_ZONES-1:0] trouble_in;
	logic [ZAAL_ZONES-1:0] btn;
	logic [ZAAL_CTLS-1:0] ctl;

	assign alarm_in = clean[ZAAL_ZONES-1:0];
	assign trouble_in = clean[2*ZAAL_ZONES-1:ZAAL_ZONES];
	assign btn = clean[3*ZAAL_ZONES-1:2*ZAAL_ZONES];
	assign ctl = clean[NIN-1:3*ZAAL_ZONES];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] zone_cfg_r;
	logic [31:0] ctl_cfg_r;
	logic [31:0] com_cfg_r;
	zaal_zone_cfg_t zcfg;
	logic silenceable;

	assign zcfg = zaal_zone_cfg_t'(zone_cfg_r);
	assign silenceable = com_cfg_r[ZAAL_SILENCE_BIT];

	// ----------------------------------------------------------------
	// control input decode
	// ----------------------------------------------------------------
	logic ack_lvl;
	logic rst_lvl;
	logic shunt_dis;
	logic shunt_mem;
	logic master_sel;
	logic master_lvl;
	logic master_armed;
	logic ack_lvl_q;
	logic rst_lvl_q;
	logic ack_cmd;
	logic rst_cmd;

	always_comb
	begin
		zaal_ctl_type_t t;
		t = ZAAL_CTL_NONE;
		ack_lvl = 1'b0;
		rst_lvl = 1'b0;
		shunt_dis = 1'b0;
		shunt_mem = 1'b0;
		master_sel = 1'b0;
		master_lvl = 1'b0;
		for (int i = 0; i < ZAAL_CTLS; i++)
		begin
			t = zaal_ctl_type_t'(ctl_cfg_r[i*ZAAL_CTL_FIELD_STRIDE +: 3]);
			if (t == ZAAL_CTL_ACK)
				ack_lvl = ack_lvl | ctl[i];
			else if (t == ZAAL_CTL_RESET)
				rst_lvl = rst_lvl | ctl[i];
			else if (t == ZAAL_CTL_SHUNT_DIS)
				shunt_dis = shunt_dis | ctl[i];
			else if (t == ZAAL_CTL_SHUNT_MEM)
				shunt_mem = shunt_mem | ctl[i];
			else if (t == ZAAL_CTL_MASTER)
			begin
				master_sel = 1'b1;
				master_lvl = master_lvl | ctl[i];
			end
		end
	end

	// no master key assigned means the panel is permanently armed
	assign master_armed = master_sel ? master_lvl : 1'b1;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ack_lvl_q <= 1'b0;
			rst_lvl_q <= 1'b0;
		end
		else
		begin
			ack_lvl_q <= ack_lvl;
			rst_lvl_q <= rst_lvl;
		end
	end

	assign ack_cmd = ack_lvl & ~ack_lvl_q;
	assign rst_cmd = rst_lvl & ~rst_lvl_q;

	// ----------------------------------------------------------------
	// zone state
	// ----------------------------------------------------------------
	logic [ZAAL_ZONES-1:0] btn_q;
	logic [ZAAL_ZONES-1:0] zone_armed;
	logic [ZAAL_ZONES-1:0] alarm;
	logic [ZAAL_ZONES-1:0] acked;
	logic [ZAAL_ZONES-1:0] fault_q;
	logic [ZAAL_ZONES-1:0] armed_eff;
	logic [ZAAL_ZONES-1:0] fault;
	logic [ZAAL_ZONES-1:0] new_alarm;
	logic [ZAAL_ZONES-1:0] press;
	logic [ZAAL_ZONES-1:0] pb_ack;
	logic [ZAAL_ZONES-1:0] pb_reset;
	logic [ZAAL_ZONES-1:0] shunted;

	// 24-hour zones stay armed whatever the master key says
	assign armed_eff = (zone_armed | zcfg.always_armed)
		& ({ZAAL_ZONES{master_armed}} | zcfg.always_armed);
	assign fault = (alarm_in & armed_eff) | trouble_in;
	assign new_alarm = fault & ~fault_q;
	assign press = btn & ~btn_q & {ZAAL_ZONES{~master_armed}};
	assign pb_ack = press & alarm & ~acked;
	assign pb_reset = press & alarm & acked;
	assign shunted = ~zone_armed & ~zcfg.always_armed;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			btn_q <= '0;
			fault_q <= '0;
		end
		else
		begin
			btn_q <= btn;
			fault_q <= fault;
		end
	end

	generate
		for (genvar z = 0; z < ZAAL_ZONES; z++)
		begin : g_zone
			// bypass toggle: only an idle zone, never a 24-hour one
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					zone_armed[z] <= 1'b1;
				else if (press[z] && !alarm[z] && !zcfg.always_armed[z] && !shunt_mem)
				begin
					if (!zone_armed[z])
						zone_armed[z] <= 1'b1;
					else if (!shunt_dis)
						zone_armed[z] <= 1'b0;
				end
			end

			// a fresh fault wins over a reset in the same cycle
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					alarm[z] <= 1'b0;
				else if (new_alarm[z])
					alarm[z] <= 1'b1;
				else if ((rst_cmd || pb_reset[z]) && !fault[z])
					alarm[z] <= 1'b0;
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					acked[z] <= 1'b0;
				else if (new_alarm[z])
					acked[z] <= 1'b0;
				else if ((ack_cmd || pb_ack[z]) && alarm[z])
					acked[z] <= 1'b1;
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					zone_sink[z] <= 1'b0;
				else if (zcfg.latching[z])
					zone_sink[z] <= alarm[z] | new_alarm[z];
				else
					zone_sink[z] <= fault[z];
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			shunt_ind <= '0;
		else
			shunt_ind <= shunted;
	end

	// ----------------------------------------------------------------
	// sounder and common outputs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sounder <= 1'b0;
		else if (|new_alarm)
			sounder <= 1'b1;
		else if (silenceable && (ack_cmd || (|pb_ack)))
			sounder <= 1'b0;
		else if (!(|alarm))
			sounder <= 1'b0;
	end

	generate
		for (genvar c = 0; c < ZAAL_COMMONS; c++)
		begin : g_com
			zaal_com_type_t ct;
			assign ct = zaal_com_type_t'(com_cfg_r[c*ZAAL_COM_FIELD_STRIDE +: 2]);
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					common_sink[c] <= 1'b0;
				else
				begin
					case (ct)
						ZAAL_COM_NONLATCH: common_sink[c] <= |fault;
						ZAAL_COM_LATCHED: common_sink[c] <= |(alarm | new_alarm);
						ZAAL_COM_AUDIBLE: common_sink[c] <= |((alarm & ~acked) | new_alarm);
						default: common_sink[c] <= |shunted;
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic aw_got;
	logic w_got;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [7:0] wa;

	assign do_write = aw_got & w_got & ~s_axi_bvalid;
	assign wa = {awaddr_q[7:2], 2'b00};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r & mask;
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ZAAL_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_got <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_got <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				if (wa == ZAAL_ZONE_CFG_OFF || wa == ZAAL_CTL_CFG_OFF || wa == ZAAL_COM_CFG_OFF)
					s_axi_bresp <= ZAAL_RESP_OKAY;
				else
					s_axi_bresp <= ZAAL_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			zone_cfg_r <= ZAAL_ZONE_CFG_RST;
			ctl_cfg_r <= ZAAL_CTL_CFG_RST;
			com_cfg_r <= ZAAL_COM_CFG_RST;
		end
		else if (do_write)
		begin
			if (wa == ZAAL_ZONE_CFG_OFF)
				zone_cfg_r <= merge(zone_cfg_r, wdata_q, wstrb_q, ZAAL_ZONE_CFG_MASK);
			else if (wa == ZAAL_CTL_CFG_OFF)
				ctl_cfg_r <= merge(ctl_cfg_r, wdata_q, wstrb_q, ZAAL_CTL_CFG_MASK);
			else if (wa == ZAAL_COM_CFG_OFF)
				com_cfg_r <= merge(com_cfg_r, wdata_q, wstrb_q, ZAAL_COM_CFG_MASK);
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic [31:0] status_w;
	logic [7:0] ra;

	assign ra = {s_axi_araddr[7:2], 2'b00};

	always_comb
	begin
		status_w = '0;
		status_w[ZAAL_ST_ALARM_LSB +: ZAAL_ZONES] = alarm;
		status_w[ZAAL_ST_ARMED_LSB +: ZAAL_ZONES] = armed_eff;
		status_w[ZAAL_ST_FAULT_LSB +: ZAAL_ZONES] = fault;
		status_w[ZAAL_ST_SOUNDER_BIT] = sounder;
		status_w[ZAAL_ST_MASTER_BIT] = master_armed;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ZAAL_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= ZAAL_RESP_OKAY;
			if (ra == ZAAL_ZONE_CFG_OFF)
				s_axi_rdata <= zone_cfg_r;
			else if (ra == ZAAL_CTL_CFG_OFF)
				s_axi_rdata <= ctl_cfg_r;
			else if (ra == ZAAL_COM_CFG_OFF)
				s_axi_rdata <= com_cfg_r;
			else if (ra == ZAAL_STATUS_OFF)
				s_axi_rdata <= status_w;
			else
			begin
				s_axi_rdata <= '0;
				s_axi_rresp <= ZAAL_RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// >>> design/zaal_pkg.sv
// constants, types and register map of the zone alarm annunciator logic
package zaal_pkg;

	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int ZAAL_ZONES = 8;
	localparam int ZAAL_CTLS = 4;
	localparam int ZAAL_COMMONS = 2;
	localparam int ZAAL_CLK_MHZ = 200;
	localparam int ZAAL_DEBOUNCE_US = 10000;
	localparam int ZAAL_DEBOUNCE_CYCLES = ZAAL_DEBOUNCE_US * ZAAL_CLK_MHZ;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ZAAL_ZONE_CFG_OFF = 8'h00;
	localparam logic [7:0] ZAAL_CTL_CFG_OFF = 8'h04;
	localparam logic [7:0] ZAAL_COM_CFG_OFF = 8'h08;
	localparam logic [7:0] ZAAL_STATUS_OFF = 8'h0C;

	// ----------------------------------------------------------------
	// writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] ZAAL_ZONE_CFG_MASK = 32'h0000_FFFF;
	localparam logic [31:0] ZAAL_CTL_CFG_MASK = 32'h0000_7777;
	localparam logic [31:0] ZAAL_COM_CFG_MASK = 32'h0000_0133;
	localparam logic [31:0] ZAAL_ZONE_CFG_RST = 32'h0000_00FF;
	localparam logic [31:0] ZAAL_CTL_CFG_RST = 32'h0000_5321;
	localparam logic [31:0] ZAAL_COM_CFG_RST = 32'h0000_0112;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ZAAL_CTL_FIELD_STRIDE = 4;
	localparam int ZAAL_COM_FIELD_STRIDE = 4;
	localparam int ZAAL_SILENCE_BIT = 8;
	localparam int ZAAL_ST_ALARM_LSB = 0;
	localparam int ZAAL_ST_ARMED_LSB = 8;
	localparam int ZAAL_ST_FAULT_LSB = 16;
	localparam int ZAAL_ST_SOUNDER_BIT = 24;
	localparam int ZAAL_ST_MASTER_BIT = 25;

	localparam logic [1:0] ZAAL_RESP_OKAY = 2'h0;
	localparam logic [1:0] ZAAL_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ZAAL_CTL_NONE = 3'h0,
		ZAAL_CTL_ACK = 3'h1,
		ZAAL_CTL_RESET = 3'h2,
		ZAAL_CTL_SHUNT_DIS = 3'h3,
		ZAAL_CTL_SHUNT_MEM = 3'h4,
		ZAAL_CTL_MASTER = 3'h5
	} zaal_ctl_type_t;

	typedef enum logic [1:0] {
		ZAAL_COM_NONLATCH = 2'h0,
		ZAAL_COM_LATCHED = 2'h1,
		ZAAL_COM_AUDIBLE = 2'h2,
		ZAAL_COM_SHUNT = 2'h3
	} zaal_com_type_t;

	typedef struct packed {
		logic [15:0] unused;
		logic [7:0] always_armed;
		logic [7:0] latching;
	} zaal_zone_cfg_t;

endpackage

// >>> verif/zaal_props.sv
// assertion checker for the zone alarm annunciator outputs
`timescale 1ns/1ps

module zaal_props
	import zaal_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ZAAL_ZONES-1:0] zone_alarm,
	input wire logic [ZAAL_ZONES-1:0] zone_trouble,
	input wire logic [ZAAL_ZONES-1:0] zone_button_n,
	input wire logic [ZAAL_CTLS-1:0] ctl_n,
	input wire logic [ZAAL_ZONES-1:0] zone_sink,
	input wire logic [ZAAL_COMMONS-1:0] common_sink,
	input wire logic sounder,
	input wire logic [ZAAL_ZONES-1:0] shunt_ind
);
	default clocking dflt_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_quiet;
		zone_sink == '0 && common_sink == '0 && !sounder;
	endsequence

	// ack or reset key, or a zone button, held down two edges ago
	sequence s_operator_act;
		$past(ctl_n[1:0], 2) != 2'h3 || $past(zone_button_n, 2) != 8'hFF;
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// debounce means nothing can light within six edges of release
	a_quiet_after_reset: assert property ($rose(aresetn) |-> s_quiet [*6])
		else $error("output active too soon after reset");

	for (genvar i = 0; i < ZAAL_ZONES; i++)
	begin : g_zone
		a_sink_needs_fault: assert property ($rose(zone_sink[i]) |->
			$past(zone_alarm[i] | zone_trouble[i], 3) && $past(zone_alarm[i] | zone_trouble[i], 5))
			else $error("zone output rose without a held fault");
		a_sink_drop_clear: assert property ($fell(zone_sink[i]) |->
			!$past(zone_alarm[i] | zone_trouble[i], 3))
			else $error("zone output fell while its input was faulted");
		a_disarmed_trouble: assert property ($rose(zone_sink[i]) && $past(ctl_n[3], 8) |->
			$past(zone_trouble[i], 3))
			else $error("zone output rose on an alarm while disarmed");
	end

	a_sounder_needs_fault: assert property ($rose(sounder) |->
		$past(zone_alarm | zone_trouble, 3) != '0)
		else $error("sounder rose without any fault");
	a_sounder_fall_cause: assert property ($fell(sounder) |-> s_operator_act)
		else $error("sounder fell without ack or reset");
	a_shunt_by_button: assert property ($changed(shunt_ind) |->
		((shunt_ind ^ $past(shunt_ind)) & ~$past(zone_button_n, 2)) != '0)
		else $error("shunt indicator changed without its button");
	a_shunt_master_off: assert property ($changed(shunt_ind) |-> $past(ctl_n[3], 8))
		else $error("shunt indicator changed while armed");
endmodule

bind zaal_annunciator zaal_props props_u (.aclk, .aresetn, .zone_alarm, .zone_trouble,
	.zone_button_n, .ctl_n, .zone_sink, .common_sink, .sounder, .shunt_ind);

// >>> verif/zaal_field.sv
// field model: zone contacts and operator switches in front of the annunciator
`timescale 1ns/1ps

module zaal_field
	import zaal_pkg::*;
(
	input wire logic [ZAAL_ZONES-1:0] alarm_req,
	input wire logic [ZAAL_ZONES-1:0] trouble_req,
	input wire logic [ZAAL_ZONES-1:0] press_req,
	input wire logic [ZAAL_CTLS-1:0] key_req,
	output logic [ZAAL_ZONES-1:0] zone_alarm,
	output logic [ZAAL_ZONES-1:0] zone_trouble,
	output logic [ZAAL_ZONES-1:0] zone_button_n,
	output logic [ZAAL_CTLS-1:0] ctl_n
);
	// switches short to ground, the pull-up holds an open line high
	assign ctl_n = ~key_req;
	assign zone_button_n = ~press_req;
	assign zone_alarm = alarm_req;
	assign zone_trouble = trouble_req;
endmodule

// >>> verif/zaal_annunciator_tb_top.sv
// self-checking testbench of the zone alarm annunciator
`timescale 1ns/1ps

module zaal_annunciator_tb_top
	import zaal_pkg::*;
;
	localparam int DB = 4;
	logic aclk;
	logic aresetn;
	logic [7:0] s_axi_awaddr;
	logic [7:0] s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp;
	logic [1:0] s_axi_rresp;
	logic [7:0] zone_alarm, zone_trouble, zone_button_n, zone_sink, shunt_ind;
	logic [7:0] alarm_req, trouble_req, press_req;
	logic [3:0] ctl_n;
	logic [3:0] key_req;
	logic [1:0] common_sink;
	logic sounder;
	int err_count;
	int check_count;

	zaal_annunciator #(.DEBOUNCE_CYCLES(DB)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .zone_alarm, .zone_trouble, .zone_button_n, .ctl_n, .zone_sink,
		.common_sink, .sounder, .shunt_ind);

	zaal_field field_u (.alarm_req, .trouble_req, .press_req, .key_req, .zone_alarm,
		.zone_trouble, .zone_button_n, .ctl_n);

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// sounder, commons, shunt lamps and zone outputs in one word
	function automatic logic [31:0] outs();
		return {7'h0, sounder, 6'h0, common_sink, shunt_ind, zone_sink};
	endfunction

	// long enough for sync, debounce and the output edge
	task automatic settle();
		repeat (DB + 8) @(posedge aclk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		chk("bresp", 32'(s_axi_bresp), 32'(er));
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		chk("rdata", s_axi_rdata, ed);
		chk("rresp", 32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'b0;
	endtask

	task automatic press(input int z);
		press_req[z] <= 1'b1;
		settle();
		press_req[z] <= 1'b0;
		settle();
	endtask

	task automatic pulse(input int k);
		key_req[k] <= 1'b1;
		settle();
		key_req[k] <= 1'b0;
		settle();
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog: the whole sequence needs well under a thousand cycles
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		err_count = 0;
		check_count = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		{alarm_req, trouble_req, press_req} = 24'h00_0000;
		key_req = 4'h8;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		chk("outs", outs(), 32'h0000_0000);
		axi_rd(ZAAL_ZONE_CFG_OFF, 32'h0000_00FF, ZAAL_RESP_OKAY);
		axi_rd(ZAAL_CTL_CFG_OFF, 32'h0000_5321, ZAAL_RESP_OKAY);
		axi_rd(ZAAL_COM_CFG_OFF, 32'h0000_0112, ZAAL_RESP_OKAY);
		axi_rd(8'h10, 32'h0000_0000, ZAAL_RESP_SLVERR);
		axi_wr(ZAAL_STATUS_OFF, 32'h0000_0000, ZAAL_RESP_SLVERR);
		$display("end registers");
		alarm_req[0] <= 1'b1;
		settle();
		chk("outs", outs(), 32'h0103_0001);
		pulse(0);
		chk("outs", outs(), 32'h0002_0001);
		alarm_req[1] <= 1'b1;
		settle();
		chk("outs", outs(), 32'h0103_0003);
		pulse(0);
		pulse(1);
		chk("outs", outs(), 32'h0002_0003);
		alarm_req <= 8'h00;
		settle();
		pulse(1);
		chk("outs", outs(), 32'h0000_0000);
		$display("end latching");
		axi_wr(ZAAL_ZONE_CFG_OFF, 32'h0000_00FE, ZAAL_RESP_OKAY);
		alarm_req[0] <= 1'b1;
		settle();
		chk("outs", outs(), 32'h0103_0001);
		axi_rd(ZAAL_STATUS_OFF, 32'h0301_FF01, ZAAL_RESP_OKAY);
		alarm_req[0] <= 1'b0;
		settle();
		chk("outs", outs(), 32'h0103_0000);
		pulse(1);
		chk("outs", outs(), 32'h0000_0000);
		$display("end non-latching");
		// common 1 non-latching until the next common config write, so it must drop with the fault
		axi_wr(ZAAL_COM_CFG_OFF, 32'h0000_0002, ZAAL_RESP_OKAY);
		alarm_req[2] <= 1'b1;
		settle();
		pulse(0);
		chk("outs", outs(), 32'h0102_0004);
		alarm_req[2] <= 1'b0;
		settle();
		chk("outs", outs(), 32'h0100_0004);
		pulse(1);
		chk("outs", outs(), 32'h0000_0000);
		$display("end steady sounder");
		press(3);
		chk("outs", outs(), 32'h0000_0000);
		key_req[3] <= 1'b0;
		settle();
		alarm_req[4] <= 1'b1;
		settle();
		chk("outs", outs(), 32'h0000_0000);
		alarm_req[4] <= 1'b0;
		trouble_req[4] <= 1'b1;
		settle();
		chk("outs", outs(), 32'h0103_0010);
		trouble_req[4] <= 1'b0;
		settle();
		press(4);
		chk("outs", outs(), 32'h0100_0010);
		press(4);
		chk("outs", outs(), 32'h0000_0000);
		$display("end master off");
		axi_wr(ZAAL_COM_CFG_OFF, 32'h0000_0113, ZAAL_RESP_OKAY);
		axi_rd(ZAAL_COM_CFG_OFF, 32'h0000_0113, ZAAL_RESP_OKAY);
		press(3);
		chk("outs", outs(), 32'h0001_0800);
		key_req[2] <= 1'b1;
		settle();
		press(5);
		chk("outs", outs(), 32'h0001_0800);
		press(3);
		chk("outs", outs(), 32'h0000_0000);
		key_req[2] <= 1'b0;
		settle();
		axi_wr(ZAAL_ZONE_CFG_OFF, 32'h0000_20FE, ZAAL_RESP_OKAY);
		press(5);
		chk("outs", outs(), 32'h0000_0000);
		axi_wr(ZAAL_CTL_CFG_OFF, 32'h0000_5421, ZAAL_RESP_OKAY);
		press(6);
		key_req[2] <= 1'b1;
		settle();
		press(6);
		press(7);
		chk("outs", outs(), 32'h0001_4000);
		key_req[2] <= 1'b0;
		$display("end shunting");
		give_verdict();
	end
endmodule
